// file: common/spi_xfer_pkg.sv
// shared constants and types for the serial transfer-format block
`default_nettype none
package spi_xfer_pkg;
  // ----------------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam logic [3:0] LAST_HALF = 4'hF;
  localparam logic [6:0] HALF_DIV_TWO = 7'h01;
  localparam logic [6:0] HALF_DIV_EIGHT = 7'h04;
  localparam logic [6:0] HALF_DIV_THIRTY_TWO = 7'h10;
  localparam logic [6:0] HALF_DIV_ONE_TWENTY_EIGHT = 7'h40;
  // ----------------------------------------------------------------------
  // rate_select encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] RATE_DIV_TWO = 2'h0;
  localparam logic [1:0] RATE_DIV_EIGHT = 2'h1;
  localparam logic [1:0] RATE_DIV_THIRTY_TWO = 2'h2;
  localparam logic [1:0] RATE_DIV_ONE_TWENTY_EIGHT = 2'h3;
  // ----------------------------------------------------------------------
  // pin synchroniser slots
  // ----------------------------------------------------------------------
  localparam int PIN_COUNT = 4;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 3;
  localparam logic [3:0] SYNC_RESET = 4'hF;
  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic TX_EMPTY_RESET = 1'b1;
  localparam logic RX_FULL_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] HALF_RESET = 4'h0;
  localparam logic [6:0] COUNT_RESET = 7'h00;

  typedef enum logic {IDLE, RUN} xfer_state_t;

  function automatic logic [6:0] half_bit_cycles(input logic [1:0] rate);
    logic [6:0] r;
    r = HALF_DIV_TWO;
    if (rate == RATE_DIV_EIGHT) begin
      r = HALF_DIV_EIGHT;
    end else if (rate == RATE_DIV_THIRTY_TWO) begin
      r = HALF_DIV_THIRTY_TWO;
    end else if (rate == RATE_DIV_ONE_TWENTY_EIGHT) begin
      r = HALF_DIV_ONE_TWENTY_EIGHT;
    end
    return r;
  endfunction : half_bit_cycles
endpackage : spi_xfer_pkg
`default_nettype wire

// file: tb/spi_far_end.sv
// behavioural far-end serial device, slave or master
`default_nettype none
module spi_far_end (
  // pins seen
  input wire logic sclkPin,
  input wire logic dataIn,
  // format
  input wire logic polarity,
  input wire logic phase,
  input wire logic selected,
  // pins driven
  output logic sclkDrv,
  output logic inFrame,
  output logic selDrv_n,
  output logic dataDrv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic [7:0] rxByte = 8'h00;
  int edges = 0;
  int bitsIn = 0;
  logic [7:0] got[$];

  initial begin
    sclkDrv = 1'b0;
    inFrame = 1'b0;
    selDrv_n = 1'b1;
  end

  assign dataDrv = sh[7];

  // ----------------------------------------------------------------------
  // shifting
  // ----------------------------------------------------------------------
  // sample, then rotate
  // rotating leaves the same byte ready for a queued second transfer
  always @(sclkPin) begin
    if (selected || inFrame) begin
      if ((sclkPin != polarity) != phase) begin
        rxByte = {rxByte[6:0], dataIn};
        bitsIn = bitsIn + 1;
        if (bitsIn % 8 == 0) begin
          got.push_back(rxByte);
        end
      end else if (edges != 0) begin
        sh = {sh[6:0], sh[7]};
      end
      edges = edges + 1;
    end
  end

  task automatic load(input logic [7:0] b);
    sh = b;
    edges = 0;
    bitsIn = 0;
  endtask : load

  task automatic frame(input logic [7:0] b, input int bits,
      input logic keepSel);
    #13;
    load(b);
    sclkDrv = polarity;
    inFrame = 1'b1;
    selDrv_n = 1'b0;
    #400;
    repeat (bits) begin
      sclkDrv = !polarity;
      #200;
      sclkDrv = polarity;
      #200;
    end
    // select holds past the last edge so the slave sees the byte end
    #200;
    inFrame = 1'b0;
    selDrv_n = !keepSel;
  endtask : frame
endmodule : spi_far_end
`default_nettype wire

// file: tb/spi_transfer_format_queue_bench.sv
// self-checking bench for the serial transfer-format block
`default_nettype none
`define CHECK_EQ(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) begin \
      num_errors++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e); \
    end \
  end
module spi_transfer_format_queue_bench import spi_xfer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spiEnable = 1'b0;
  logic masterSelect = 1'b0;
  logic clockPolarity = 1'b0;
  logic clockPhase = 1'b0;
  logic [1:0] rateSelect = 2'h0;
  logic dataWrite = 1'b0;
  logic [7:0] writeData = 8'h00;
  logic statusRead = 1'b0;
  logic dataRead = 1'b0;
  logic farSel = 1'b0;
  logic noise = 1'b0;
  logic [7:0] readData;
  logic txEmptyFlag, rxFullFlag, sclkOut, sclkOe_n;
  logic mosiOut, mosiOe_n, misoOut, misoOe_n;
  logic farClk, farFrame, farSel_n, farData;
  wire logic sclkW, mosiW, misoW, selW;
  int num_errors = 0;
  int check_count = 0;

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // released data lines toggle so a stale level never reads as data
  always @(negedge clk) noise <= !noise;
  assign sclkW = !sclkOe_n ? sclkOut : farFrame ? farClk : clockPolarity;
  assign mosiW = !mosiOe_n ? mosiOut : farFrame ? farData : noise;
  assign misoW = !misoOe_n ? misoOut : farSel ? farData : noise;
  assign selW = masterSelect ? 1'b1 : farSel_n;

  spi_transfer_format_queue dut (
    .clk(clk), .rst(rst), .clkEn(1'b1),
    .spiEnable(spiEnable), .masterSelect(masterSelect),
    .clockPolarity(clockPolarity), .clockPhase(clockPhase),
    .rateSelect(rateSelect), .dataWrite(dataWrite),
    .writeData(writeData), .statusRead(statusRead), .dataRead(dataRead),
    .readData(readData), .txEmptyFlag(txEmptyFlag),
    .rxFullFlag(rxFullFlag), .serialClockIn(sclkW),
    .serialClockOut(sclkOut), .serialClockOe_n(sclkOe_n),
    .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe_n(mosiOe_n),
    .misoIn(misoW), .misoOut(misoOut), .misoOe_n(misoOe_n),
    .slaveSelect_n(selW));

  spi_far_end far (.sclkPin(sclkW), .dataIn(masterSelect ? mosiW : misoW),
    .polarity(clockPolarity), .phase(clockPhase), .selected(farSel),
    .sclkDrv(farClk), .inFrame(farFrame), .selDrv_n(farSel_n),
    .dataDrv(farData));

  initial begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] b);
    @(posedge clk);
    dataWrite <= 1'b1;
    writeData <= b;
    @(posedge clk);
    dataWrite <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] exp);
    int n;
    n = 0;
    while (rxFullFlag !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHECK_EQ(rxFullFlag, 1'b1)
    `CHECK_EQ(readData, exp)
    @(posedge clk);
    statusRead <= 1'b1;
    @(posedge clk);
    statusRead <= 1'b0;
    dataRead <= 1'b1;
    @(posedge clk);
    dataRead <= 1'b0;
    #1;
    `CHECK_EQ(rxFullFlag, 1'b0)
  endtask : rd

  task automatic farGot(input logic [7:0] exp);
    logic [7:0] b;
    b = (far.got.size() > 0) ? far.got.pop_front() : ~exp;
    `CHECK_EQ(b, exp)
  endtask : farGot

  task automatic cfg(input logic m, pol, ph, input logic [1:0] rate);
    @(posedge clk);
    farSel <= 1'b0;
    spiEnable <= 1'b0;
    @(posedge clk);
    masterSelect <= m;
    clockPolarity <= pol;
    clockPhase <= ph;
    rateSelect <= rate;
    repeat (4) @(posedge clk);
    spiEnable <= 1'b1;
    @(posedge clk);
    #1;
  endtask : cfg

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    int n;
    int half;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHECK_EQ(txEmptyFlag, 1'b1)
    `CHECK_EQ(rxFullFlag, 1'b0)
    `CHECK_EQ(readData, 8'h00)
    `CHECK_EQ(sclkOut, 1'b0)
    // every format and every rate, two queued bytes each
    for (int i = 0; i < 4; i++) begin
      cfg(1'b1, i[1], i[0], i[1:0]);
      half = 1 << (2 * i);
      far.load(8'hC3 ^ i[7:0]);
      farSel = 1'b1;
      wr(8'h50 + i[7:0]);
      `CHECK_EQ(txEmptyFlag, 1'b0)
      n = 0;
      while (sclkOut === clockPolarity && n < 300) begin
        @(posedge clk);
        #1;
        n++;
      end
      `CHECK_EQ(n <= (i[0] ? 2 : 3) * half + 3, 1'b1)
      `CHECK_EQ(txEmptyFlag, 1'b1)
      wr(8'hA0 + i[7:0]);
      rd(8'hC3 ^ i[7:0]);
      rd(8'hC3 ^ i[7:0]);
      farGot(8'h50 + i[7:0]);
      farGot(8'hA0 + i[7:0]);
    end
    @(posedge clk);
    spiEnable <= 1'b0;
    @(posedge clk);
    #1;
    `CHECK_EQ(sclkOe_n, 1'b1)
    `CHECK_EQ(sclkOut, clockPolarity)
    // slave, phase 0
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    `CHECK_EQ(misoOe_n, 1'b1)
    wr(8'h96);
    repeat (3) @(posedge clk);
    #1;
    `CHECK_EQ(txEmptyFlag, 1'b1)
    fork
      far.frame(8'h69, 8, 1'b0);
      begin
        repeat (8) @(posedge clk);
        #1;
        `CHECK_EQ(misoOe_n, 1'b0)
        `CHECK_EQ(misoOut, 1'b1)
      end
    join
    rd(8'h69);
    farGot(8'h96);
    far.frame(8'h11, 8, 1'b0);
    rd(8'h11);
    farGot(8'h69);
    // slave, phase 1, write lands mid transfer
    cfg(1'b0, 1'b0, 1'b1, 2'h0);
    wr(8'hE7);
    fork
      far.frame(8'h24, 8, 1'b1);
      begin
        repeat (30) @(posedge clk);
        wr(8'h81);
        repeat (20) @(posedge clk);
        #1;
        `CHECK_EQ(txEmptyFlag, 1'b0)
      end
    join
    rd(8'h24);
    farGot(8'hE7);
    far.frame(8'h42, 8, 1'b0);
    rd(8'h42);
    farGot(8'h81);
    // select released mid transfer
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    far.frame(8'hF0, 4, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    `CHECK_EQ(misoOe_n, 1'b1)
    `CHECK_EQ(rxFullFlag, 1'b0)
    conclude();
  end

  // run needs about 160 us; a hang is cut at about six times that
  initial begin
    #1_000_000;
    num_errors++;
    conclude();
  end
endmodule : spi_transfer_format_queue_bench
`default_nettype wire

// file: verilog/spi_rate_divider.sv
// free-running half-bit tick generator for the master serial clock
`default_nettype none
module spi_rate_divider
  import spi_xfer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // control
  input wire logic run,
  input wire logic [1:0] rateSelect,
  // tick out
  output logic halfTick
);
  logic [6:0] count;
  logic [6:0] next_count;
  logic next_halfTick;

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  // gated free-run
  // runs regardless of transfers so start latency floats up to a half-bit time
  always_comb begin
    next_count = count;
    next_halfTick = 1'b0;
    if (!run) begin
      next_count = COUNT_RESET;
    end else if (count + 7'h01 >= half_bit_cycles(rateSelect)) begin
      next_count = COUNT_RESET;
      next_halfTick = 1'b1;
    end else begin
      next_count = count + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= COUNT_RESET;
      halfTick <= 1'b0;
    end else if (clkEn) begin
      count <= next_count;
      halfTick <= next_halfTick;
    end
  end
endmodule : spi_rate_divider
`default_nettype wire

// file: verilog/spi_transfer_format_queue.sv
// serial transfer engine with clock format control and transmit queue
`default_nettype none
module spi_transfer_format_queue
  import spi_xfer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // configuration
  input wire logic spiEnable,
  input wire logic masterSelect,
  input wire logic clockPolarity,
  input wire logic clockPhase,
  input wire logic [1:0] rateSelect,
  // software access
  input wire logic dataWrite,
  input wire logic [7:0] writeData,
  input wire logic statusRead,
  input wire logic dataRead,
  output logic [7:0] readData,
  output logic txEmptyFlag,
  output logic rxFullFlag,
  // serial clock pin
  input wire logic serialClockIn,
  output logic serialClockOut,
  output logic serialClockOe_n,
  // data pins
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe_n,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe_n,
  // slave select pin
  input wire logic slaveSelect_n
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] syncA;
  logic [PIN_COUNT-1:0] syncB;
  logic [PIN_COUNT-1:0] syncC;

  assign pinRaw[PIN_SCLK] = serialClockIn;
  assign pinRaw[PIN_SEL] = slaveSelect_n;
  assign pinRaw[PIN_MOSI] = mosiIn;
  assign pinRaw[PIN_MISO] = misoIn;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : gSync
      always_ff @(posedge clk) begin
        if (rst) begin
          syncA[g] <= SYNC_RESET[g];
          syncB[g] <= SYNC_RESET[g];
          syncC[g] <= SYNC_RESET[g];
        end else if (clkEn) begin
          syncA[g] <= pinRaw[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // rate divider
  // ----------------------------------------------------------------------
  logic divTick;
  logic rateRun;

  assign rateRun = spiEnable && masterSelect;

  spi_rate_divider uDivider (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .run(rateRun),
    .rateSelect(rateSelect),
    .halfTick(divTick)
  );

  // ----------------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------------
  xfer_state_t state, next_state;
  logic [3:0] halfIdx, next_halfIdx;
  logic [7:0] shiftReg, next_shiftReg;
  logic [7:0] txBuf, next_txBuf;
  logic [7:0] next_readData;
  logic txFull, next_txFull;
  logic active, next_active;
  logic sampleBit, next_sampleBit;
  logic rxFull, next_rxFull;
  logic clearArm, next_clearArm;
  // master miso lags its own clock by the two pin stages
  logic [1:0] lateSample, next_lateSample;
  logic [7:0] rxShift, next_rxShift;
  logic [2:0] rxBits, next_rxBits;
  logic slaveSel, slaveOff, selFall, sclkEdge, sclkLead, pinIn;
  logic tick, sampleTick, loadShift, doneXfer, inBit;

  assign slaveSel = !syncB[PIN_SEL];
  assign slaveOff = !masterSelect && !slaveSel;
  assign selFall = syncC[PIN_SEL] && !syncB[PIN_SEL];
  assign sclkEdge = syncB[PIN_SCLK] != syncC[PIN_SCLK];
  assign sclkLead = sclkEdge && (syncB[PIN_SCLK] != clockPolarity);
  assign pinIn = masterSelect ? syncB[PIN_MISO] : syncB[PIN_MOSI];
  assign tick = (state == RUN) && spiEnable &&
                (masterSelect ? divTick : (sclkEdge && slaveSel));
  assign sampleTick = tick && (halfIdx[0] == clockPhase);
  assign inBit = sampleTick ? pinIn : sampleBit;
  assign doneXfer = tick && (halfIdx == LAST_HALF);
  assign loadShift = spiEnable && txFull && (state == IDLE);

  always_comb begin
    next_state = state;
    next_halfIdx = halfIdx;
    next_shiftReg = shiftReg;
    next_active = active;
    next_sampleBit = sampleBit;
    next_txBuf = txBuf;
    next_txFull = txFull;
    next_readData = readData;
    next_rxFull = rxFull;
    next_clearArm = clearArm;
    next_rxShift = rxShift;
    next_rxBits = rxBits;
    next_lateSample = {lateSample[0], sampleTick && masterSelect};
    if (dataWrite) begin
      next_txBuf = writeData;
      next_txFull = 1'b1;
    end else if (loadShift) begin
      next_txFull = 1'b0;
    end
    if (statusRead && rxFull) begin
      next_clearArm = 1'b1;
    end
    if (dataRead && clearArm) begin
      next_rxFull = 1'b0;
      next_clearArm = 1'b0;
    end
    if (!spiEnable) begin
      next_state = IDLE;
      next_halfIdx = HALF_RESET;
      next_active = 1'b0;
      next_lateSample = 2'h0;
      next_rxBits = 3'h0;
    end else begin
      case (state)
        IDLE: begin
          next_halfIdx = HALF_RESET;
          next_active = 1'b0;
          // buffer moves on the next cycle
          if (loadShift) begin
            next_shiftReg = txBuf;
          end
          if (masterSelect) begin
            if (loadShift) begin
              next_state = RUN;
            end
          end else if (slaveSel) begin
            if (!clockPhase && selFall) begin
              next_state = RUN;
            end else if (clockPhase && sclkLead) begin
              next_state = RUN;
              next_halfIdx = 4'h1;
            end
          end
        end
        RUN: begin
          if (slaveOff) begin
            next_state = IDLE;
          end else if (tick) begin
            // every tick is one serial clock edge
            next_active = !active;
            next_halfIdx = halfIdx + 4'h1;
            if (sampleTick) begin
              next_sampleBit = pinIn;
            end
            if ((!sampleTick && !(clockPhase && halfIdx == HALF_RESET)) ||
                doneXfer) begin
              next_shiftReg = {shiftReg[6:0], inBit};
            end
            if (doneXfer) begin
              next_state = IDLE;
              if (!masterSelect) begin
                next_readData = {shiftReg[6:0], inBit};
                next_rxFull = 1'b1;
                next_clearArm = 1'b0;
              end
            end
          end
        end
        default: next_state = IDLE;
      endcase
    end
    // master capture lands two cycles after its clock edge
    if (spiEnable && masterSelect && lateSample[1]) begin
      next_rxShift = {rxShift[6:0], pinIn};
      next_rxBits = rxBits + 3'h1;
      if (rxBits == 3'h7) begin
        next_readData = {rxShift[6:0], pinIn};
        next_rxFull = 1'b1;
        next_clearArm = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= IDLE;
      halfIdx <= HALF_RESET;
      shiftReg <= DATA_RESET;
      txBuf <= DATA_RESET;
      readData <= DATA_RESET;
      txFull <= !TX_EMPTY_RESET;
      active <= 1'b0;
      sampleBit <= 1'b0;
      rxFull <= RX_FULL_RESET;
      clearArm <= 1'b0;
      lateSample <= 2'h0;
      rxShift <= DATA_RESET;
      rxBits <= 3'h0;
    end else if (clkEn) begin
      state <= next_state;
      halfIdx <= next_halfIdx;
      shiftReg <= next_shiftReg;
      txBuf <= next_txBuf;
      readData <= next_readData;
      txFull <= next_txFull;
      active <= next_active;
      sampleBit <= next_sampleBit;
      rxFull <= next_rxFull;
      clearArm <= next_clearArm;
      lateSample <= next_lateSample;
      rxShift <= next_rxShift;
      rxBits <= next_rxBits;
    end
  end

  // ----------------------------------------------------------------------
  // flags and pins
  // ----------------------------------------------------------------------
  assign txEmptyFlag = !txFull;
  assign rxFullFlag = rxFull;
  // edges land on bus clock; pad timing places them mid low phase
  assign serialClockOut = clockPolarity ^ active;
  assign serialClockOe_n = !rateRun;
  assign mosiOut = shiftReg[7];
  assign mosiOe_n = !rateRun;
  assign misoOut = shiftReg[7];
  assign misoOe_n = !(spiEnable && !masterSelect && slaveSel);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence masterWriteIdle;
    dataWrite && clkEn && spiEnable && masterSelect && state == IDLE &&
      !txFull;
  endsequence

  sequence twoLiveCycles;
    (clkEn && spiEnable && masterSelect)[*2];
  endsequence

  write_clears_empty_a: assert property (
    @(posedge clk) disable iff (rst)
    dataWrite && clkEn |=> !txEmptyFlag)
    else $error("write did not clear transmit empty");

  refill_sets_empty_a: assert property (
    @(posedge clk) disable iff (rst)
    loadShift && clkEn && !dataWrite |=> txEmptyFlag && shiftReg == $past(txBuf))
    else $error("buffer move did not set transmit empty");

  master_starts_a: assert property (
    @(posedge clk) disable iff (rst)
    masterWriteIdle ##1 twoLiveCycles |-> state == RUN)
    else $error("master write did not start a transfer");

  miso_release_a: assert property (
    @(posedge clk) disable iff (rst)
    syncB[PIN_SEL] |-> misoOe_n)
    else $error("miso driven while deselected");

  rx_capture_a: assert property (
    @(posedge clk) disable iff (rst)
    doneXfer && clkEn && !masterSelect |=>
      rxFullFlag && readData == shiftReg)
    else $error("received byte not captured");

  master_capture_a: assert property (
    @(posedge clk) disable iff (rst)
    spiEnable && masterSelect && lateSample[1] && rxBits == 3'h7 && clkEn
      |=> rxFullFlag)
    else $error("master received byte not flagged");

  slave_holds_a: assert property (
    @(posedge clk) disable iff (rst)
    state == RUN && !masterSelect |-> !loadShift)
    else $error("shift register loaded during slave transfer");

  idle_clock_a: assert property (
    @(posedge clk) disable iff (rst)
    state == IDLE && rateRun |-> serialClockOut == clockPolarity)
    else $error("serial clock not at idle level");

  reset_state_a: assert property (
    @(posedge clk)
    rst |=> txEmptyFlag && !rxFullFlag && state == IDLE)
    else $error("wrong state after reset");

  divider_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    !rateRun && clkEn ##1 !rateRun |-> !divTick)
    else $error("serial clock ticks while not master");
endmodule : spi_transfer_format_queue
`default_nettype wire
